// ---- hw/operand_decoder.sv ----
/*
  Operand decoder: takes opcode and addressing byte, fetches displacement bytes,
  forms the effective address, picks registers, segment and clock count.
  Assumes bytes arrive from the prefetch queue one per valid cycle, in stream order,
  and that register values are supplied by the execution unit.
*/
`include "dec_defs.svh"

// Contract
// [RQ1] Xor writes dst^src, clears carry, overflow
// [RQ2] Rm field selects base pair for address
// [RQ3] Mode 00 rm 110 uses direct address
// [RQ4] Mode 01 sign-extends byte; 10 two bytes
// [RQ5] Mode 11 rm is register, no displacement
// [RQ6] Mode 00 otherwise zero displacement
// [RQ7] Displacement follows addressing byte, before data
// [RQ8] BP-based addresses default to stack segment
// [RQ9] String destination always extra segment
// [RQ10] Reg field selects word or byte register
// [RQ11] Shift kind field selects shift operation
// [RQ12] Escape passes coprocessor fields through
// [RQ13] Move forms decoded with their clock counts
// [RQ14] Segment moves decoded, 2/9 and 2/11
// [RQ15] Width pairs: first byte, second word
// [RQ16] Table translate, single byte, 11 clocks
// [RQ17] Jump and interrupt pair ordering kept; jump and interrupt opcodes are not decoded here
// [RQ18] Translate reads at BX plus AL
// [RQ19] Push and pop forms with counts
// [RQ20] Exchange, input, output forms decoded
// [RQ21] Width bit picks byte or word
module operand_decoder (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        seg_override_i,
  input  wire logic [1:0]  seg_override_sel_i,
  input  wire logic        string_dst_i,
  input  wire logic [15:0] bx_i,
  input  wire logic [15:0] bp_i,
  input  wire logic [15:0] si_i,
  input  wire logic [15:0] di_i,
  input  wire logic [7:0]  al_i,
  input  wire logic        xor_strobe_i,
  input  wire logic [15:0] xor_dst_i,
  input  wire logic [15:0] xor_src_i,
  output logic             byte_ready_o,
  output logic             dec_done_o,
  output logic [7:0]       opcode_o,
  output logic [4:0]       op_class_o,
  output logic             word_o,
  output logic             mem_op_o,
  output logic [15:0]      effective_addr_o,
  output logic [1:0]       seg_o,
  output logic [3:0]       reg_sel_o,
  output logic [3:0]       rm_reg_sel_o,
  output logic [2:0]       shift_kind_field_o,
  output logic [2:0]       copro_op_high_o,
  output logic [2:0]       copro_op_low_o,
  output logic [7:0]       clocks_o,
  output logic [15:0]      xor_result_o,
  output logic [4:0]       xor_flags_o,
  output logic             xor_flags_we_o
);
  // ----------------------------------------------------------------
  // Byte sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OPC = 5'h01, ST_MODRM = 5'h02, ST_DLO = 5'h04, ST_DHI = 5'h08, ST_DONE = 5'h10
  } state_t;

  state_t      state_q;
  logic [7:0]  opc_q;
  logic [7:0]  modrm_q;
  logic [7:0]  dlo_q;
  logic [7:0]  dhi_q;
  logic        take;

  function automatic logic needs_modrm(input logic [7:0] op);
    needs_modrm = (op[7:1] == `OP_MOV_RM_R) || (op[7:1] == `OP_MOV_R_RM)
               || (op[7:1] == `OP_MOV_I_RM) || (op == `OP_MOV_RM_SEG)
               || (op == `OP_MOV_SEG_RM) || (op == `OP_PUSH_MEM)
               || (op == `OP_POP_MEM) || (op[7:1] == `OP_XCHG_RM)
               || (op[7:3] == `OP_ESC) || (op[7:2] == `OP_XOR_RM);
  endfunction

  // Displacement byte count from the addressing byte
  function automatic logic [1:0] disp_len(input logic [7:0] m);
    case (m[`MOD_HI:`MOD_LO])
      `MOD_NODISP: disp_len = (m[`RM_HI:`RM_LO] == `RM_DIRECT) ? 2'h2 : 2'h0;
      `MOD_DISP8:  disp_len = 2'h1;
      `MOD_DISP16: disp_len = 2'h2;
      default:     disp_len = 2'h0;
    endcase
  endfunction

  assign take = byte_valid_i && byte_ready_o;

  // [RQ7] Displacement after addressing byte
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_OPC;
    end else begin
      case (state_q)
        ST_OPC:   if (take) state_q <= needs_modrm(byte_i) ? ST_MODRM : ST_DONE;
        // [RQ5] Register mode skips displacement
        ST_MODRM: if (take) state_q <= (disp_len(byte_i) == 2'h0) ? ST_DONE : ST_DLO;
        // [RQ4] One or two displacement bytes
        ST_DLO:   if (take) state_q <= (disp_len(modrm_q) == 2'h2) ? ST_DHI : ST_DONE;
        ST_DHI:   if (take) state_q <= ST_DONE;
        ST_DONE:  state_q <= ST_OPC;
        default:  state_q <= ST_OPC;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opc_q   <= 8'h00;
      modrm_q <= 8'h00;
      dlo_q   <= 8'h00;
      dhi_q   <= 8'h00;
    end else if (take) begin
      case (state_q)
        ST_OPC: begin
          opc_q   <= byte_i;
          modrm_q <= 8'h00;
          dlo_q   <= 8'h00;
          dhi_q   <= 8'h00;
        end
        ST_MODRM: modrm_q <= byte_i;
        ST_DLO:   dlo_q   <= byte_i;
        ST_DHI:   dhi_q   <= byte_i;
        default:  opc_q   <= opc_q;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_ready_o <= 1'b0;
    end else begin
      // Ready stays low through ST_DONE and the cycle after it so outputs settle before the next opcode
      byte_ready_o <= !((state_q == ST_DONE) || (take && (state_q == ST_DHI
                     || (state_q == ST_OPC && !needs_modrm(byte_i))
                     || (state_q == ST_MODRM && disp_len(byte_i) == 2'h0)
                     || (state_q == ST_DLO && disp_len(modrm_q) != 2'h2))));
    end
  end

  // ----------------------------------------------------------------
  // Combinational decode of the captured bytes
  // ----------------------------------------------------------------
  logic [1:0]           md;
  logic [2:0]           rg;
  logic [2:0]           rm;
  logic                 w;
  logic                 has_mrm;
  logic                 mem;
  logic [15:0]          disp;
  logic [15:0]          ea;
  dec_pkg::base_sel_t   base;
  dec_pkg::seg_t        seg;
  dec_pkg::op_class_t   cls;
  logic [7:0]           clk;

  assign md      = modrm_q[`MOD_HI:`MOD_LO];
  assign rg      = modrm_q[`REG_HI:`REG_LO];
  assign rm      = modrm_q[`RM_HI:`RM_LO];
  assign has_mrm = needs_modrm(opc_q);
  // [RQ5] Mode 11 is a register operand
  assign mem     = has_mrm && (md != `MOD_REG);

  // [RQ2] Base from rm field
  always_comb begin
    base = dec_pkg::BASE_NONE;
    if (mem) begin
      // [RQ3] Direct address has no base
      if (md == `MOD_NODISP && rm == `RM_DIRECT) base = dec_pkg::BASE_NONE;
      else base = dec_pkg::base_sel_t'({1'b0, rm});
    end
  end

  // [RQ4] Sign extension of short displacement
  always_comb begin
    case (md)
      `MOD_DISP8:  disp = {{8{dlo_q[7]}}, dlo_q};
      `MOD_DISP16: disp = {dhi_q, dlo_q};
      // [RQ6] Zero displacement unless direct
      `MOD_NODISP: disp = (rm == `RM_DIRECT) ? {dhi_q, dlo_q} : 16'h0000;
      default:     disp = 16'h0000;
    endcase
  end

  always_comb begin
    case (base)
      dec_pkg::BASE_BX_SI: ea = bx_i + si_i + disp;
      dec_pkg::BASE_BX_DI: ea = bx_i + di_i + disp;
      dec_pkg::BASE_BP_SI: ea = bp_i + si_i + disp;
      dec_pkg::BASE_BP_DI: ea = bp_i + di_i + disp;
      dec_pkg::BASE_SI:    ea = si_i + disp;
      dec_pkg::BASE_DI:    ea = di_i + disp;
      dec_pkg::BASE_BP:    ea = bp_i + disp;
      dec_pkg::BASE_BX:    ea = bx_i + disp;
      default:             ea = disp;
    endcase
    // [RQ18] Translate at BX plus AL
    if (opc_q == `OP_XLAT) ea = bx_i + {8'h00, al_i};
  end

  // [RQ8] BP bases pick stack segment
  always_comb begin
    seg = dec_pkg::SEG_DS;
    if (base == dec_pkg::BASE_BP_SI || base == dec_pkg::BASE_BP_DI
        || base == dec_pkg::BASE_BP) seg = dec_pkg::SEG_SS;
    if (seg_override_i) seg = dec_pkg::seg_t'(seg_override_sel_i);
    // [RQ9] String destination fixed to extra segment
    if (string_dst_i) seg = dec_pkg::SEG_ES;
  end

  // [RQ21] Width bit zero is byte
  assign w = ((opc_q[7:4] == `OP_MOV_I_R) ? opc_q[3] : opc_q[0]);

  // [RQ10] Register code with width
  function automatic logic [3:0] reg_code(input logic wide, input logic [2:0] f);
    reg_code = {wide, f};
  endfunction

  // Pick class and clock count; pairs are byte/word or register/memory
  always_comb begin
    cls = dec_pkg::OPC_NONE;
    clk = 8'h00;
    if (opc_q[7:1] == `OP_MOV_RM_R) begin
      // [RQ13] Move forms
      cls = dec_pkg::OPC_MOV;
      clk = mem ? `CLK_MOV_RM_R_M : `CLK_MOV_RM_R_R;
    end else if (opc_q[7:1] == `OP_MOV_R_RM) begin
      cls = dec_pkg::OPC_MOV;
      clk = mem ? `CLK_MOV_R_RM_M : `CLK_MOV_RM_R_R;
    end else if (opc_q[7:1] == `OP_MOV_I_RM) begin
      // [RQ15] First figure byte, second word
      cls = dec_pkg::OPC_MOV;
      clk = w ? `CLK_MOV_I_RM_W : `CLK_MOV_I_RM_B;
    end else if (opc_q[7:4] == `OP_MOV_I_R) begin
      cls = dec_pkg::OPC_MOV;
      clk = w ? `CLK_MOV_I_R_W : `CLK_MOV_I_R_B;
    end else if (opc_q[7:1] == `OP_MOV_M_A) begin
      cls = dec_pkg::OPC_MOV;
      clk = `CLK_MOV_M_A;
    end else if (opc_q[7:1] == `OP_MOV_A_M) begin
      cls = dec_pkg::OPC_MOV;
      clk = `CLK_MOV_A_M;
    end else if (opc_q == `OP_MOV_RM_SEG) begin
      // [RQ14] Segment moves
      cls = dec_pkg::OPC_MOV_SEG;
      clk = mem ? `CLK_MOV_R_RM_M : `CLK_MOV_RM_R_R;
    end else if (opc_q == `OP_MOV_SEG_RM) begin
      cls = dec_pkg::OPC_MOV_SEG;
      clk = mem ? `CLK_SEG_RM_M : `CLK_MOV_RM_R_R;
    end else if (opc_q == `OP_PUSH_MEM && rg == `FLD_PUSH_MEM) begin
      // [RQ19] Push and pop forms
      cls = dec_pkg::OPC_PUSH;
      clk = `CLK_PUSH_MEM;
    end else if (opc_q[7:3] == `OP_PUSH_R) begin
      cls = dec_pkg::OPC_PUSH;
      clk = `CLK_PUSH_R;
    end else if (opc_q[7:5] == 3'h0 && opc_q[2:0] == `SEG_PUSH_LO) begin
      cls = dec_pkg::OPC_PUSH;
      clk = `CLK_PUSH_SEG;
    end else if (opc_q == `OP_PUSH_IMM || opc_q == `OP_PUSH_IMM_S) begin
      cls = dec_pkg::OPC_PUSH;
      clk = `CLK_PUSH_R;
    end else if (opc_q == `OP_POP_MEM) begin
      cls = dec_pkg::OPC_POP;
      clk = `CLK_POP_MEM;
    end else if (opc_q[7:3] == `OP_POP_R) begin
      cls = dec_pkg::OPC_POP;
      clk = `CLK_PUSH_R;
    end else if (opc_q[7:5] == 3'h0 && opc_q[2:0] == `SEG_POP_LO
                 && opc_q[4:3] != `SEG_POP_CS) begin
      cls = dec_pkg::OPC_POP;
      clk = `CLK_POP_SEG;
    end else if (opc_q == `OP_PUSHA) begin
      cls = dec_pkg::OPC_PUSHA;
      clk = `CLK_PUSHA;
    end else if (opc_q == `OP_POPA) begin
      cls = dec_pkg::OPC_POPA;
      clk = `CLK_POPA;
    end else if (opc_q[7:1] == `OP_XCHG_RM) begin
      // [RQ20] Exchange and port forms
      cls = dec_pkg::OPC_XCHG;
      clk = mem ? `CLK_XCHG_M : `CLK_XCHG_R;
    end else if (opc_q[7:3] == `OP_XCHG_A) begin
      cls = dec_pkg::OPC_XCHG;
      clk = `CLK_XCHG_A;
    end else if (opc_q == `OP_XLAT) begin
      // [RQ16] Single byte translate
      cls = dec_pkg::OPC_XLAT;
      clk = `CLK_XLAT;
    end else if (opc_q[7:1] == `OP_IN_FIX) begin
      cls = dec_pkg::OPC_IN;
      clk = `CLK_IN_FIX;
    end else if (opc_q[7:1] == `OP_IN_VAR) begin
      cls = dec_pkg::OPC_IN;
      clk = `CLK_IN_VAR;
    end else if (opc_q[7:1] == `OP_OUT_FIX) begin
      cls = dec_pkg::OPC_OUT;
      clk = `CLK_OUT_FIX;
    end else if (opc_q[7:1] == `OP_OUT_VAR) begin
      cls = dec_pkg::OPC_OUT;
      clk = `CLK_OUT_VAR;
    end else if (opc_q[7:3] == `OP_ESC) begin
      cls = dec_pkg::OPC_ESC;
    end else if (opc_q[7:2] == `OP_XOR_RM) begin
      cls = dec_pkg::OPC_XOR;
      clk = mem ? `CLK_XOR_M : `CLK_XOR_R;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs, loaded when decode completes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_done_o         <= 1'b0;
      opcode_o           <= 8'h00;
      op_class_o         <= 5'h00;
      word_o             <= 1'b0;
      mem_op_o           <= 1'b0;
      effective_addr_o   <= 16'h0000;
      seg_o              <= 2'h3;
      reg_sel_o          <= 4'h0;
      rm_reg_sel_o       <= 4'h0;
      shift_kind_field_o <= 3'h0;
      copro_op_high_o    <= 3'h0;
      copro_op_low_o     <= 3'h0;
      clocks_o           <= 8'h00;
    end else begin
      dec_done_o <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        opcode_o           <= opc_q;
        op_class_o         <= cls;
        word_o             <= w;
        mem_op_o           <= mem;
        effective_addr_o   <= ea;
        seg_o              <= seg;
        // [RQ10] Register selection
        reg_sel_o          <= reg_code(w, (opc_q[7:4] == `OP_MOV_I_R) ? opc_q[2:0] : rg);
        rm_reg_sel_o       <= reg_code(w, rm);
        // [RQ11] Shift kind passthrough
        shift_kind_field_o <= rg;
        // [RQ12] Coprocessor fields passthrough
        copro_op_high_o    <= opc_q[2:0];
        copro_op_low_o     <= rg;
        clocks_o           <= clk;
      end
    end
  end

  // [RQ17] Conditional jump and interrupt pairs lie outside this group; no count here

  // ----------------------------------------------------------------
  // Exclusive-or datapath
  // ----------------------------------------------------------------
  dec_xor_unit #(.WIDTH(16)) u_xor (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .strobe_i   (xor_strobe_i),
    .word_i     (word_o),
    .dst_i      (xor_dst_i),
    .src_i      (xor_src_i),
    .result_o   (xor_result_o),
    .carry_o    (xor_flags_o[0]),
    .ovf_o      (xor_flags_o[1]),
    .parity_o   (xor_flags_o[2]),
    .sign_o     (xor_flags_o[3]),
    .zero_o     (xor_flags_o[4]),
    .flags_we_o (xor_flags_we_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_modrm_reg;
    state_q == ST_MODRM && take && byte_i[`MOD_HI:`MOD_LO] == `MOD_REG;
  endsequence
  p_reg_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_modrm_reg |=> state_q == ST_DONE ##1 !mem_op_o)
    else $error("register mode fetched displacement"); // RQ5
  p_disp8: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DLO && take && modrm_q[`MOD_HI:`MOD_LO] == `MOD_DISP8) |=> state_q == ST_DONE)
    else $error("short displacement took two bytes"); // RQ4
  p_direct: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DONE && mem && md == `MOD_NODISP && rm == `RM_DIRECT && opc_q != `OP_XLAT)
    |=> effective_addr_o == {$past(dhi_q), $past(dlo_q)})
    else $error("direct address wrong"); // RQ3
  p_zero_disp: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_MODRM && take && byte_i[`MOD_HI:`MOD_LO] == `MOD_NODISP
     && byte_i[`RM_HI:`RM_LO] != `RM_DIRECT) |=> state_q == ST_DONE)
    else $error("mode 00 fetched displacement"); // RQ6
  p_bx_si: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DONE && base == dec_pkg::BASE_BX_SI && opc_q != `OP_XLAT)
    |=> effective_addr_o == $past(bx_i + si_i + disp))
    else $error("base pair address wrong"); // RQ2
  p_bp_seg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DONE && base == dec_pkg::BASE_BP && !seg_override_i && !string_dst_i)
    |=> seg_o == dec_pkg::SEG_SS)
    else $error("bp address not on stack segment"); // RQ8
  p_str_es: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DONE && string_dst_i) |=> seg_o == dec_pkg::SEG_ES)
    else $error("string destination not extra segment"); // RQ9
  p_xlat: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_OPC && take && byte_i == `OP_XLAT) ##1 1'b1 ##1 1'b1
    |-> clocks_o == `CLK_XLAT && dec_done_o)
    else $error("translate decode wrong"); // RQ16
  p_imm_pair: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == ST_DONE && opc_q[7:4] == `OP_MOV_I_R)
    |=> clocks_o == (opc_q[3] ? `CLK_MOV_I_R_W : `CLK_MOV_I_R_B))
    else $error("width clock pair wrong"); // RQ15
endmodule

// ---- pkg/dec_defs.svh ----
/*
  Shared constants of the operand decoder: field positions, opcode codes, clock counts.
  Assumes it is included by its bare name from the decoder files.
*/
`ifndef DEC_DEFS_SVH
`define DEC_DEFS_SVH

`define MOD_HI          7
`define MOD_LO          6
`define REG_HI          5
`define REG_LO          3
`define RM_HI           2
`define RM_LO           0
`define MOD_NODISP      2'h0
`define MOD_DISP8       2'h1
`define MOD_DISP16      2'h2
`define MOD_REG         2'h3
`define RM_DIRECT       3'h6
`define FLD_PUSH_MEM    3'h6

`define OP_MOV_RM_R     7'h44
`define OP_MOV_R_RM     7'h45
`define OP_MOV_I_RM     7'h63
`define OP_MOV_I_R      4'hb
`define OP_MOV_M_A      7'h50
`define OP_MOV_A_M      7'h51
`define OP_MOV_RM_SEG   8'h8e
`define OP_MOV_SEG_RM   8'h8c
`define OP_PUSH_MEM     8'hff
`define OP_PUSH_R       5'h0a
`define OP_PUSH_IMM     8'h68
`define OP_PUSH_IMM_S   8'h6a
`define OP_POP_MEM      8'h8f
`define OP_POP_R        5'h0b
`define OP_PUSHA        8'h60
`define OP_POPA         8'h61
`define OP_XCHG_RM      7'h43
`define OP_XCHG_A       5'h12
`define OP_XLAT         8'hd7
`define OP_IN_FIX       7'h72
`define OP_IN_VAR       7'h76
`define OP_OUT_FIX      7'h73
`define OP_OUT_VAR      7'h77
`define OP_ESC          5'h1b
`define OP_XOR_RM       6'h0c
`define SEG_PUSH_LO     3'h6
`define SEG_POP_LO      3'h7
`define SEG_POP_CS      2'h1

`define CLK_MOV_RM_R_R  8'h02
`define CLK_MOV_RM_R_M  8'h0c
`define CLK_MOV_R_RM_M  8'h09
`define CLK_MOV_I_RM_B  8'h0c
`define CLK_MOV_I_RM_W  8'h0d
`define CLK_MOV_I_R_B   8'h03
`define CLK_MOV_I_R_W   8'h04
`define CLK_MOV_M_A     8'h09
`define CLK_MOV_A_M     8'h08
`define CLK_SEG_RM_M    8'h0b
`define CLK_PUSH_MEM    8'h10
`define CLK_PUSH_R      8'h0a
`define CLK_PUSH_SEG    8'h09
`define CLK_POP_MEM     8'h14
`define CLK_POP_SEG     8'h08
`define CLK_PUSHA       8'h24
`define CLK_POPA        8'h33
`define CLK_XCHG_R      8'h04
`define CLK_XCHG_M      8'h11
`define CLK_XCHG_A      8'h03
`define CLK_XLAT        8'h0b
`define CLK_IN_FIX      8'h0a
`define CLK_IN_VAR      8'h08
`define CLK_OUT_FIX     8'h09
`define CLK_OUT_VAR     8'h07
`define CLK_XOR_R       8'h03
`define CLK_XOR_M       8'h0a

`endif

// ---- pkg/dec_pkg.sv ----
/*
  Types of the operand decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dec_pkg;
  typedef enum logic [3:0] {
    BASE_BX_SI = 4'h0, BASE_BX_DI = 4'h1, BASE_BP_SI = 4'h2, BASE_BP_DI = 4'h3,
    BASE_SI    = 4'h4, BASE_DI    = 4'h5, BASE_BP    = 4'h6, BASE_BX    = 4'h7,
    BASE_NONE  = 4'h8
  } base_sel_t;
  typedef enum logic [1:0] {SEG_ES = 2'h0, SEG_CS = 2'h1, SEG_SS = 2'h2, SEG_DS = 2'h3} seg_t;
  typedef enum logic [2:0] {
    SH_ROL = 3'h0, SH_ROR = 3'h1, SH_RCL = 3'h2, SH_RCR = 3'h3,
    SH_SHL = 3'h4, SH_SHR = 3'h5, SH_NONE = 3'h6, SH_SAR = 3'h7
  } shift_kind_t;
  typedef enum logic [4:0] {
    OPC_NONE = 5'h00, OPC_MOV = 5'h01, OPC_MOV_SEG = 5'h02, OPC_PUSH = 5'h03,
    OPC_POP = 5'h04, OPC_PUSHA = 5'h05, OPC_POPA = 5'h06, OPC_XCHG = 5'h07,
    OPC_XLAT = 5'h08, OPC_IN = 5'h09, OPC_OUT = 5'h0a, OPC_ESC = 5'h0b,
    OPC_XOR = 5'h0c
  } op_class_t;
endpackage

// ---- hw/dec_xor_unit.sv ----
/*
  Exclusive-or datapath with its flag effects, byte or word wide.
  Assumes operands are stable when strobe_i is high; result appears one cycle later.
*/
module dec_xor_unit #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             strobe_i,
  input  wire logic             word_i,
  input  wire logic [WIDTH-1:0] dst_i,
  input  wire logic [WIDTH-1:0] src_i,
  output logic      [WIDTH-1:0] result_o,
  output logic                  carry_o,
  output logic                  ovf_o,
  output logic                  parity_o,
  output logic                  sign_o,
  output logic                  zero_o,
  output logic                  flags_we_o
);
  initial begin
    if (WIDTH != 16) $error("dec_xor_unit supports WIDTH 16 only");
  end

  logic [WIDTH-1:0] res;
  assign res = dst_i ^ src_i;

  // [RQ1] Xor flag update
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o   <= '0;
      carry_o    <= 1'b0;
      ovf_o      <= 1'b0;
      parity_o   <= 1'b0;
      sign_o     <= 1'b0;
      zero_o     <= 1'b0;
      flags_we_o <= 1'b0;
    end else begin
      flags_we_o <= strobe_i;
      if (strobe_i) begin
        result_o <= word_i ? res : {{(WIDTH-8){1'b0}}, res[7:0]};
        carry_o  <= 1'b0;
        ovf_o    <= 1'b0;
        // Parity looks at the low byte only, as the flag always has
        parity_o <= ~^res[7:0];
        sign_o   <= word_i ? res[WIDTH-1] : res[7];
        zero_o   <= word_i ? (res == '0) : (res[7:0] == 8'h00);
      end
    end
  end

  p_xor_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    strobe_i |=> (carry_o == 1'b0) && (ovf_o == 1'b0)
              && (result_o[7:0] == ($past(dst_i[7:0]) ^ $past(src_i[7:0])))
              && flags_we_o)
    else $error("xor result or flags wrong"); // RQ1
endmodule

// ---- sim/prefetch_model.sv ----
/*
  Prefetch queue model: offers queued instruction bytes to the decoder.
  Assumes a byte is taken at a rising edge while valid and ready are both high.
*/
module prefetch_model (
  input  wire logic       core_clk_i,
  input  wire logic       byte_ready_i,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] q[$];
  logic [7:0] last_q;
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h5a;
    last_q = 8'h5a;
  end
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  // Leftover bytes are dropped at once so the decoder cannot take them
  task automatic flush();
    q.delete();
  endtask
  always @(posedge core_clk_i) begin
    if (byte_valid_o && byte_ready_i && q.size() > 0) begin
      last_q = q.pop_front();
    end
    #1;
    byte_valid_o = q.size() > 0;
    // An idle line shows the inverse, never a stale byte
    byte_o = byte_valid_o ? q[0] : ~last_q;
  end
endmodule

// ---- sim/operand_decoder_tb.sv ----
/*
  Self-checking bench of the operand decoder.
  Assumes the prefetch model feeds bytes and the bench drives register values.
*/
module operand_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, rst_n_i, byte_valid_i, byte_ready_o, dec_done_o, word_o, mem_op_o;
  logic seg_override_i = 1'b0, string_dst_i = 1'b0, xor_strobe_i = 1'b0, xor_flags_we_o;
  logic [1:0] seg_override_sel_i = 2'h0, seg_o;
  logic [15:0] bx_i = 16'h1000, bp_i = 16'h2000, si_i = 16'h0030, di_i = 16'h0400;
  logic [15:0] xor_dst_i = 16'h0, xor_src_i = 16'h0, effective_addr_o, xor_result_o;
  logic [7:0] al_i = 8'h05, byte_i, opcode_o, clocks_o;
  logic [4:0] op_class_o, xor_flags_o;
  logic [3:0] reg_sel_o, rm_reg_sel_o;
  logic [2:0] shift_kind_field_o, copro_op_high_o, copro_op_low_o;
  int miscompares = 0, num_checks = 0, lft;
  operand_decoder operand_decoder_inst (.core_clk_i, .rst_n_i, .byte_valid_i, .byte_i,
    .seg_override_i, .seg_override_sel_i, .string_dst_i, .bx_i, .bp_i, .si_i, .di_i, .al_i,
    .xor_strobe_i, .xor_dst_i, .xor_src_i, .byte_ready_o, .dec_done_o, .opcode_o,
    .op_class_o, .word_o, .mem_op_o, .effective_addr_o, .seg_o, .reg_sel_o, .rm_reg_sel_o,
    .shift_kind_field_o, .copro_op_high_o, .copro_op_low_o, .clocks_o, .xor_result_o,
    .xor_flags_o, .xor_flags_we_o);
  prefetch_model prefetch_model_inst (.core_clk_i, .byte_ready_i(byte_ready_o),
    .byte_valid_o(byte_valid_i), .byte_o(byte_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sends n bytes, waits for the decode, counts the bytes left untaken
  task automatic issue(input int n, input logic [47:0] b);
    int k;
    for (k = 0; k < n; k++) prefetch_model_inst.put(b[47-8*k -: 8]);
    for (k = 0; k < 30; k++) begin
      @(posedge core_clk_i);
      #1;
      if (dec_done_o === 1'b1) break;
    end
    if (k == 30) begin
      miscompares++;
      end_of_test();
    end
    lft = prefetch_model_inst.q.size();
    chk("ready refused", 16'(byte_ready_o), 16'h0);
    prefetch_model_inst.flush();
  endtask
  task automatic xop(input logic [15:0] d, s, r, input logic [4:0] f);
    xor_dst_i = d;
    xor_src_i = s;
    xor_strobe_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    xor_strobe_i = 1'b0;
    chk("xor result", xor_result_o, r);
    chk("xor flags", 16'(xor_flags_o), 16'(f));
    chk("xor we", 16'(xor_flags_we_o), 16'h1);
    @(posedge core_clk_i);
    #1;
    chk("xor we drop", 16'(xor_flags_we_o), 16'h0);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regreg();
    issue(2, 48'h89d8_0000_0000);
    chk("opcode", 16'(opcode_o), 16'h89);
    chk("mem op", 16'(mem_op_o), 16'h0);
    chk("reg sel", 16'(reg_sel_o), 16'hb);
    chk("rm sel", 16'(rm_reg_sel_o), 16'h8);
    chk("clocks", 16'(clocks_o), 16'h2);
    chk("word", 16'(word_o), 16'h1);
    xop(16'h00ff, 16'h0f0f, 16'h0ff0, 5'h04);
    xop(16'h8000, 16'h8000, 16'h0000, 5'h14);
  endtask
  task automatic t_mem();
    issue(3, 48'h8a46_fe00_0000);
    chk("ea bp8", effective_addr_o, 16'h1ffe);
    chk("seg bp", 16'(seg_o), 16'(dec_pkg::SEG_SS));
    chk("reg byte", 16'(reg_sel_o), 16'h0);
    chk("clocks", 16'(clocks_o), 16'h9);
    issue(4, 48'h8887_0001_0000);
    chk("ea d16", effective_addr_o, 16'h1100);
    chk("seg bx", 16'(seg_o), 16'(dec_pkg::SEG_DS));
    chk("clocks", 16'(clocks_o), 16'hc);
    issue(6, 48'hc706_3412_7856);
    chk("ea direct", effective_addr_o, 16'h1234);
    chk("left", 16'(lft), 16'h2);
    chk("clocks", 16'(clocks_o), 16'hd);
    issue(3, 48'h8b01_aa00_0000);
    chk("ea nodisp", effective_addr_o, 16'h1400);
    chk("left", 16'(lft), 16'h1);
    issue(2, 48'hb455_0000_0000);
    chk("reg imm", 16'(reg_sel_o), 16'h4);
    chk("clocks", 16'(clocks_o), 16'h3);
  endtask
  task automatic t_seg();
    string_dst_i = 1'b1;
    seg_override_i = 1'b1;
    seg_override_sel_i = 2'h2;
    issue(2, 48'h8b05_0000_0000);
    chk("seg dst", 16'(seg_o), 16'(dec_pkg::SEG_ES));
    chk("ea di", effective_addr_o, 16'h0400);
    string_dst_i = 1'b0;
    seg_override_i = 1'b0;
  endtask
  task automatic t_misc();
    logic [15:0] tbl[4] = '{16'h550a, 16'h6024, 16'h6133, 16'h0e09};
    issue(3, 48'hdd58_1000_0000);
    chk("copro hi", 16'(copro_op_high_o), 16'h5);
    chk("copro lo", 16'(copro_op_low_o), 16'h3);
    chk("shift", 16'(shift_kind_field_o), 16'h3);
    chk("ea esc", effective_addr_o, 16'h1040);
    issue(1, 48'hd700_0000_0000);
    chk("class", 16'(op_class_o), 16'(dec_pkg::OPC_XLAT));
    chk("clocks", 16'(clocks_o), 16'hb);
    chk("ea xlat", effective_addr_o, 16'h1005);
    issue(2, 48'h8ed8_0000_0000);
    chk("seg move", 16'(op_class_o), 16'(dec_pkg::OPC_MOV_SEG));
    chk("clocks", 16'(clocks_o), 16'h2);
    issue(1, 48'he600_0000_0000);
    chk("out clocks", 16'(clocks_o), 16'h9);
    foreach (tbl[i]) begin
      issue(1, {tbl[i][15:8], 40'h0});
      chk("stack clocks", 16'(clocks_o), 16'(tbl[i][7:0]));
    end
  endtask
  initial begin
    rst_n_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_regreg();
    t_mem();
    t_seg();
    t_misc();
    end_of_test();
  end
endmodule
